// ### hw/fcd_decoder.sv
// fp coprocessor, indexed fp group and cop2 opcode decoder, registered result
module fcd_decoder
    import fcd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [31:0] instr_in,
    input  wire logic        fp64_enable_in,
    output fcd_result_t      result_out
);
    // ==========================================================
    // field extraction
    wire logic [5:0] major   = instr_in[FCD_OP_HI:FCD_OP_LO];
    wire logic [4:0] fmt     = instr_in[FCD_FMT_HI:FCD_FMT_LO];
    wire logic [2:0] fn_row  = instr_in[FCD_FN_HI:FCD_FN_HI-2];
    wire logic [2:0] fn_col  = instr_in[FCD_FN_LO+2:FCD_FN_LO];
    wire logic [2:0] short_format_field = instr_in[FCD_SHORT_FORMAT_FIELD_HI:FCD_SHORT_FORMAT_FIELD_LO];
    wire logic       true_false_select_bit = instr_in[FCD_TF_BIT];
    wire logic [1:0] rs_row  = fmt[4:3];
    wire logic [2:0] rs_col  = fmt[2:0];

    wire logic is_cop1 = (major == FCD_OP_COP1);
    wire logic is_cop2 = (major == FCD_OP_COP2);
    wire logic fp_indexed_opcode_group = (major == FCD_OP_FP_INDEXED_OPCODE_GROUP);

    // ==========================================================
    // format decode, shared by both format widths
    function automatic fcd_dtype_t dt_of_fmt(input logic [4:0] f);
        unique case (f)
            FCD_FMT_S:  dt_of_fmt = FCD_DT_SINGLE;
            FCD_FMT_D:  dt_of_fmt = FCD_DT_DOUBLE;
            FCD_FMT_W:  dt_of_fmt = FCD_DT_WORD;
            FCD_FMT_L:  dt_of_fmt = FCD_DT_LONG;
            FCD_FMT_PS: dt_of_fmt = FCD_DT_PAIRED;
            default:    dt_of_fmt = (f <= FCD_FMT_MOVE_MAX) ? FCD_DT_NONE
                                                             : FCD_DT_RSVD;
        endcase
    endfunction

    // short code is the low bits of the long code with bits 4:3 forced to 10
    function automatic fcd_dtype_t dt_of_short_format_field(input logic [2:0] f3);
        dt_of_short_format_field = dt_of_fmt({2'b10, f3});
    endfunction

    // ==========================================================
    // cop1 decode
    wire fcd_dtype_t c1_dt      = dt_of_fmt(fmt);
    wire logic       c1_xfer    = (fmt <= FCD_FMT_MOVE_MAX);
    wire logic       c1_sd      = (c1_dt == FCD_DT_SINGLE) || (c1_dt == FCD_DT_DOUBLE);
    wire logic       c1_wl      = (c1_dt == FCD_DT_WORD) || (c1_dt == FCD_DT_LONG);
    // transfer space: row 00 moves at cols 0,2,3,4,6,7; row 01 col 0 branch
    wire logic c1_mv_ok = (rs_row == 2'b00) && (rs_col != 3'h1) && (rs_col != 3'h5);
    wire logic c1_br_ok = (rs_row == 2'b01) && (rs_col == 3'h0);
    wire logic convert_to_single_col = (fn_col == 3'h0) && (c1_dt != FCD_DT_SINGLE);
    wire logic convert_to_double_col = (fn_col == 3'h1) && (c1_dt != FCD_DT_DOUBLE);

    fcd_opclass_t c1_opc;
    // paired-single function space is not populated on this core, so it is reserved
    always_comb begin
        c1_opc = FCD_OPC_NONE;
        if (c1_xfer) begin
            if (c1_mv_ok)
                c1_opc = FCD_OPC_C1_MOVE;
            else if (c1_br_ok)
                c1_opc = FCD_OPC_C1_BRANCH;
        end else if (c1_sd) begin
            unique case (fn_row)
                3'h0: c1_opc = FCD_OPC_ARITH;
                3'h1: c1_opc = FCD_OPC_ROUND;
                3'h2: begin
                    if (fn_col == 3'h1 || fn_col == 3'h2 || fn_col == 3'h3)
                        c1_opc = FCD_OPC_CONDMOVE;
                    else if (fn_col == 3'h5 || fn_col == 3'h6)
                        c1_opc = FCD_OPC_RECIP;
                end
                3'h4: begin
                    if (convert_to_single_col)
                        c1_opc = FCD_OPC_CONVERT_TO_SINGLE;
                    else if (convert_to_double_col)
                        c1_opc = FCD_OPC_CONVERT_TO_DOUBLE;
                    else if (fn_col == 3'h4)
                        c1_opc = FCD_OPC_CVT_W;
                    else if (fn_col == 3'h5)
                        c1_opc = FCD_OPC_CVT_L;
                end
                default: c1_opc = FCD_OPC_NONE;
            endcase
        end else if (c1_wl && fn_row == 3'h4) begin
            if (fn_col == 3'h0)
                c1_opc = FCD_OPC_CONVERT_TO_SINGLE;
            else if (fn_col == 3'h1)
                c1_opc = FCD_OPC_CONVERT_TO_DOUBLE;
        end
    end

    // ==========================================================
    // indexed fp group decode
    wire fcd_dtype_t x_f3_dt = dt_of_short_format_field(short_format_field);
    wire logic x_ld  = (fn_row == 3'h0) && (fn_col == 3'h0 || fn_col == 3'h1
                                            || fn_col == 3'h5);
    wire logic x_st  = (fn_row == 3'h1) && (fn_col == 3'h0 || fn_col == 3'h1
                                            || fn_col == 3'h5);
    wire logic x_pf  = (fn_row == 3'h1) && (fn_col == 3'h7);
    wire logic x_fma = fn_row[2] && (fn_col == 3'h0 || fn_col == 3'h1);
    wire fcd_opclass_t x_opc = x_ld  ? FCD_OPC_XLOAD  :
                               x_st  ? FCD_OPC_XSTORE :
                               x_pf  ? FCD_OPC_XPREF  :
                               x_fma ? FCD_OPC_FMA    : FCD_OPC_NONE;
    // fma type comes from the column: 0 single, 1 double
    wire fcd_dtype_t x_dt = x_fma ? (fn_col[0] ? FCD_DT_DOUBLE : FCD_DT_SINGLE)
                                  : FCD_DT_NONE;

    // ==========================================================
    // cop2 decode
    wire logic c2_mv = (rs_row == 2'b00) && (rs_col != 3'h1) && (rs_col != 3'h5);
    wire logic c2_br = (rs_row == 2'b01) && (rs_col == 3'h0);
    wire fcd_opclass_t c2_opc = rs_row[1] ? FCD_OPC_C2_OP :
                                c2_mv     ? FCD_OPC_C2_MOVE :
                                c2_br     ? FCD_OPC_C2_BRANCH : FCD_OPC_NONE;

    // ==========================================================
    // result assembly
    fcd_result_t next_result;
    always_comb begin
        next_result = FCD_RESULT_RST;
        next_result.tf  = true_false_select_bit;
        next_result.sub = fn_col;
        if (is_cop1) begin
            next_result.valid    = 1'b1;
            next_result.dtype    = c1_dt;
            next_result.opclass  = c1_opc;
            next_result.sub      = c1_xfer ? rs_col : fn_col;
            next_result.reserved = (c1_opc == FCD_OPC_NONE);
            next_result.illegal  = (c1_dt == FCD_DT_LONG) && !fp64_enable_in;
        end else if (fp_indexed_opcode_group) begin
            next_result.valid    = 1'b1;
            next_result.dtype    = x_fma ? x_dt : FCD_DT_NONE;
            next_result.opclass  = x_opc;
            // short formats 2, 3 and 7 have no type: flag it only on indexed stores
            next_result.reserved = (x_opc == FCD_OPC_NONE)
                                   || (x_st && x_f3_dt == FCD_DT_RSVD);
            next_result.illegal  = !fp64_enable_in;
        end else if (is_cop2) begin
            next_result.valid    = 1'b1;
            next_result.opclass  = c2_opc;
            next_result.sub      = rs_col;
            next_result.reserved = (c2_opc == FCD_OPC_NONE);
        end
    end

    // registered so the pipeline stage sees a flop-driven result
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            result_out <= FCD_RESULT_RST;
        else
            result_out <= next_result;
    end
endmodule

// ### hw/fcd_pkg.sv
// package for the fp / cop2 opcode decoder: field positions, encodings, types
package fcd_pkg;
    // ==========================================================
    // instruction field positions
    localparam int FCD_OP_HI    = 31;
    localparam int FCD_OP_LO    = 26;
    localparam int FCD_FMT_HI   = 25;
    localparam int FCD_FMT_LO   = 21;
    localparam int FCD_FN_HI    = 5;
    localparam int FCD_FN_LO    = 0;
    localparam int FCD_SHORT_FORMAT_FIELD_HI  = 2;
    localparam int FCD_SHORT_FORMAT_FIELD_LO  = 0;
    localparam int FCD_TF_BIT   = 16;

    // ==========================================================
    // major opcodes of the groups handled here
    localparam logic [5:0] FCD_OP_COP1  = 6'h11;
    localparam logic [5:0] FCD_OP_COP2  = 6'h12;
    localparam logic [5:0] FCD_OP_FP_INDEXED_OPCODE_GROUP = 6'h13;

    // ==========================================================
    // format encodings (5-bit field and short 3-bit field)
    localparam logic [4:0] FCD_FMT_MOVE_MAX = 5'h0f;
    localparam logic [4:0] FCD_FMT_S        = 5'h10;
    localparam logic [4:0] FCD_FMT_D        = 5'h11;
    localparam logic [4:0] FCD_FMT_W        = 5'h14;
    localparam logic [4:0] FCD_FMT_L        = 5'h15;
    localparam logic [4:0] FCD_FMT_PS       = 5'h16;
    localparam logic [2:0] FCD_F3_S         = 3'h0;
    localparam logic [2:0] FCD_F3_D         = 3'h1;
    localparam logic [2:0] FCD_F3_W         = 3'h4;
    localparam logic [2:0] FCD_F3_L         = 3'h5;
    localparam logic [2:0] FCD_F3_PS        = 3'h6;

    // ==========================================================
    // decoded data type
    typedef enum logic [2:0] {
        FCD_DT_NONE   = 3'h0,
        FCD_DT_SINGLE = 3'h1,
        FCD_DT_DOUBLE = 3'h2,
        FCD_DT_WORD   = 3'h3,
        FCD_DT_LONG   = 3'h4,
        FCD_DT_PAIRED = 3'h5,
        FCD_DT_RSVD   = 3'h6
    } fcd_dtype_t;

    // decoded operation class
    typedef enum logic [4:0] {
        FCD_OPC_NONE      = 5'h00,
        FCD_OPC_ARITH     = 5'h01,
        FCD_OPC_ROUND     = 5'h02,
        FCD_OPC_CONDMOVE  = 5'h03,
        FCD_OPC_RECIP     = 5'h04,
        FCD_OPC_CONVERT_TO_SINGLE     = 5'h05,
        FCD_OPC_CONVERT_TO_DOUBLE     = 5'h06,
        FCD_OPC_CVT_W     = 5'h07,
        FCD_OPC_CVT_L     = 5'h08,
        FCD_OPC_XLOAD     = 5'h09,
        FCD_OPC_XSTORE    = 5'h0a,
        FCD_OPC_XPREF     = 5'h0b,
        FCD_OPC_FMA       = 5'h0c,
        FCD_OPC_C1_MOVE   = 5'h0d,
        FCD_OPC_C1_BRANCH = 5'h0e,
        FCD_OPC_C2_MOVE   = 5'h0f,
        FCD_OPC_C2_BRANCH = 5'h10,
        FCD_OPC_C2_OP     = 5'h11
    } fcd_opclass_t;

    // decoder result bundle
    typedef struct packed {
        logic         valid;     // instruction belongs to a handled group
        fcd_dtype_t   dtype;
        fcd_opclass_t opclass;
        logic [2:0]   sub;       // column within the row (which op)
        logic         tf;        // true/false select for fp-flag moves
        logic         reserved;  // reserved encoding
        logic         illegal;   // 64-bit fp disabled on a long-format or indexed op, even if reserved
    } fcd_result_t;

    localparam fcd_result_t FCD_RESULT_RST = '0;
endpackage

// ### verification/fcd_decoder_chk.sv
// checker of the fp / cop2 decoder result against its instruction inputs
module fcd_decoder_chk
    import fcd_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [31:0] instr_in,
    input  wire logic        fp64_enable_in,
    input  fcd_result_t      result_out
);
    // ==========================================================
    // field split, result lags the word by one edge
    wire       is_c1  = instr_in[31:26] == FCD_OP_COP1;
    wire       is_x   = instr_in[31:26] == FCD_OP_FP_INDEXED_OPCODE_GROUP;
    wire       is_c2  = instr_in[31:26] == FCD_OP_COP2;
    wire [4:0] fmt    = instr_in[25:21];
    wire [5:0] fn     = instr_in[5:0];
    wire [2:0] fn_col = instr_in[2:0];
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_move; is_c1 && fmt <= FCD_FMT_MOVE_MAX |=> result_out.reserved ||
        result_out.opclass inside {FCD_OPC_C1_MOVE, FCD_OPC_C1_BRANCH}; endproperty
    a_move: assert property (p_move) else $error("transfer space misdecoded");
    property p_single; is_c1 && fmt == FCD_FMT_S |=> result_out.dtype == FCD_DT_SINGLE; endproperty
    a_single: assert property (p_single) else $error("single type lost");
    property p_rsvd_fmt; is_c1 && fmt > FCD_FMT_PS |=> result_out.reserved; endproperty
    a_rsvd_fmt: assert property (p_rsvd_fmt) else $error("high format not flagged");
    property p_long; is_c1 && fmt == FCD_FMT_L && !fp64_enable_in |=> result_out.illegal;
    endproperty
    a_long: assert property (p_long) else $error("long accepted with fp64 off");
    property p_xill; is_x |=> result_out.valid && result_out.illegal != $past(fp64_enable_in);
    endproperty
    a_xill: assert property (p_xill) else $error("indexed legality wrong");
    property p_add; is_c1 && fmt == FCD_FMT_S && fn[5:3] == 3'h0 |=> !result_out.reserved &&
        result_out.opclass == FCD_OPC_ARITH && result_out.sub == $past(fn_col); endproperty
    a_add: assert property (p_add) else $error("arithmetic row misdecoded");
    property p_fma; is_x && fn[5] && fn[2:1] == 2'h0 |=> result_out.opclass == FCD_OPC_FMA &&
        result_out.dtype == ($past(fn_col) == 3'h1 ? FCD_DT_DOUBLE : FCD_DT_SINGLE); endproperty
    a_fma: assert property (p_fma) else $error("fused op misdecoded");
    property p_c2op; is_c2 && fmt[4] |=> result_out.opclass == FCD_OPC_C2_OP; endproperty
    a_c2op: assert property (p_c2op) else $error("cop2 operation lost");
    property p_xrsvd; is_x && fn[5:4] == 2'h1 |=> result_out.reserved; endproperty
    a_xrsvd: assert property (p_xrsvd) else $error("empty indexed row not flagged");
endmodule

// ### verification/fcd_decoder_tb.sv
// self-checking bench of the fp / cop2 opcode decoder
module fcd_decoder_tb import fcd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in          = 1'h0;
    logic        rst_n_in        = 1'h0;
    logic [31:0] instr_in        = 32'h0;
    logic        fp64_enable_in  = 1'h1;
    fcd_result_t result_out;
    int          num_errors      = 0;
    int          samples_checked = 0;
    // ==========================================================
    // clock and device
    always #20 clk_in = ~clk_in;
    fcd_decoder fcd_decoder_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
                               .fp64_enable_in(fp64_enable_in), .result_out(result_out));
    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // masked compare: fields the rules leave open are not judged
    task automatic cmp(input fcd_result_t got, input fcd_result_t exp, input fcd_result_t msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk)) begin
            num_errors++;
            $display("[FAIL] %0t word %h got %h exp %h", $time, instr_in, got, exp);
        end
    endtask
    // drive at the falling edge, judge after one rising edge; calls run back to back
    task automatic try(input logic [5:0] op, input logic [4:0] f, input logic [5:0] fn,
                       input logic fp, input fcd_opclass_t oc, input fcd_dtype_t dt,
                       input logic rsv, input logic ill);
        logic       vld;
        logic [2:0] sub;
        vld = op[5:2] == 4'h4 && op[1:0] != 2'h0;
        sub = (op == FCD_OP_COP2 || (op == FCD_OP_COP1 && !f[4])) ? f[2:0] : fn[2:0];
        // bit 16 follows fn bit 0 so the copied true/false select is exercised both ways
        instr_in = {op, f, 4'h0, fn[0], 10'h0, fn};
        fp64_enable_in = fp;
        @(negedge clk_in);
        cmp(result_out, {vld, dt, oc, sub, fn[0], rsv, ill},
            {1'h1, {3{dt != FCD_DT_NONE}}, {5{oc != FCD_OPC_NONE}}, {3{vld && !rsv}}, 3'h7});
    endtask
    // ==========================================================
    // scenarios
    task automatic s_formats();
        fcd_dtype_t dt;
        for (int f = 16; f < 32; f++) begin
            dt = f == 16 ? FCD_DT_SINGLE : f == 17 ? FCD_DT_DOUBLE : f == 20 ? FCD_DT_WORD
               : f == 21 ? FCD_DT_LONG : f == 22 ? FCD_DT_PAIRED : FCD_DT_RSVD;
            try(FCD_OP_COP1, 5'(f), 6'h20, 1'h1, FCD_OPC_NONE, dt, !(f inside {17, 20, 21}),
                1'h0);
        end
    endtask
    task automatic s_moves();
        try(FCD_OP_COP1, 5'h00, 6'h00, 1'h1, FCD_OPC_C1_MOVE, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP1, 5'h07, 6'h00, 1'h1, FCD_OPC_C1_MOVE, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP1, 5'h08, 6'h00, 1'h1, FCD_OPC_C1_BRANCH, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP1, 5'h0c, 6'h00, 1'h1, FCD_OPC_NONE, FCD_DT_NONE, 1'h1, 1'h0);
    endtask
    task automatic s_arith();
        for (int c = 0; c < 8; c++) begin
            try(FCD_OP_COP1, FCD_FMT_S, 6'(c), 1'h0, FCD_OPC_ARITH, FCD_DT_SINGLE, 1'h0, 1'h0);
        end
        try(FCD_OP_COP1, FCD_FMT_D, 6'h20, 1'h1, FCD_OPC_CONVERT_TO_SINGLE, FCD_DT_DOUBLE, 1'h0, 1'h0);
        try(FCD_OP_COP1, FCD_FMT_S, 6'h25, 1'h1, FCD_OPC_CVT_L, FCD_DT_SINGLE, 1'h0, 1'h0);
        try(FCD_OP_COP1, FCD_FMT_D, 6'h18, 1'h1, FCD_OPC_NONE, FCD_DT_NONE, 1'h1, 1'h0);
        try(FCD_OP_COP1, FCD_FMT_L, 6'h21, 1'h0, FCD_OPC_CONVERT_TO_DOUBLE, FCD_DT_LONG, 1'h0, 1'h1);
        try(FCD_OP_COP1, FCD_FMT_W, 6'h21, 1'h0, FCD_OPC_CONVERT_TO_DOUBLE, FCD_DT_WORD, 1'h0, 1'h0);
    endtask
    // each indexed case twice: illegal clear with fp64 on, set with it off
    task automatic s_indexed();
        for (int p = 1; p >= 0; p--) begin
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h05, 1'(p), FCD_OPC_XLOAD, FCD_DT_NONE, 1'h0, !p);
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h09, 1'(p), FCD_OPC_XSTORE, FCD_DT_NONE, 1'h0, !p);
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h0f, 1'(p), FCD_OPC_XPREF, FCD_DT_NONE, 1'h0, !p);
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h30, 1'(p), FCD_OPC_FMA, FCD_DT_SINGLE, 1'h0, !p);
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h39, 1'(p), FCD_OPC_FMA, FCD_DT_DOUBLE, 1'h0, !p);
            try(FCD_OP_FP_INDEXED_OPCODE_GROUP, 5'h0, 6'h12, 1'(p), FCD_OPC_NONE, FCD_DT_NONE, 1'h1, !p);
        end
    endtask
    task automatic s_cop2();
        try(FCD_OP_COP2, 5'h03, 6'h00, 1'h1, FCD_OPC_C2_MOVE, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP2, 5'h07, 6'h00, 1'h1, FCD_OPC_C2_MOVE, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP2, 5'h08, 6'h00, 1'h1, FCD_OPC_C2_BRANCH, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP2, 5'h1f, 6'h00, 1'h1, FCD_OPC_C2_OP, FCD_DT_NONE, 1'h0, 1'h0);
        try(FCD_OP_COP2, 5'h09, 6'h00, 1'h1, FCD_OPC_NONE, FCD_DT_NONE, 1'h1, 1'h0);
        try(6'h00, 5'h10, 6'h00, 1'h1, FCD_OPC_NONE, FCD_DT_NONE, 1'h0, 1'h0);
    endtask
    // reset held four cycles, result must stay cleared
    initial begin
        repeat (4) @(negedge clk_in);
        cmp(result_out, '0, '1);
        rst_n_in = 1'h1;
        s_formats();
        s_moves();
        s_arith();
        s_indexed();
        s_cop2();
        close_out();
    end
endmodule
bind fcd_decoder fcd_decoder_chk fcd_decoder_chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .instr_in(instr_in), .fp64_enable_in(fp64_enable_in), .result_out(result_out));
